// ### verilog/pfr_ctrl.sv
/*
 * fault response and recovery controller: qualifies comparator flags,
 * runs the current fault retry timer, drives the load sense pulldown
 * and combines faults into the two fet driver enables.
 * assumes comparator flags and control pins are asynchronous levels.
 */
`timescale 1ns/1ps
`default_nettype none
module pfr_ctrl
    import pfr_pkg::*;
#(
    parameter int unsigned       TICK_DIV    = TICK_CYC,
    parameter logic [CNT_W-1:0]  RETRY_TICKS = DLY_RETRY
) (
    input  wire logic            core_clk_i,
    input  wire logic            rst_i,
    input  wire pfr_pkg::pfr_cmp_s cmp_i,
    input  wire logic            load_sense_pin_i,
    input  wire logic            charge_enable_input_i,
    input  wire logic            discharge_enable_input_i,
    input  wire logic [1:0]      chg_rec_mode_i,
    input  wire logic [1:0]      dsg_rec_mode_i,
    input  wire logic            dsg_hot_need_load_i,
    input  wire logic            low_volt_need_load_i,
    output logic                 load_sense_pin_o,
    output logic                 load_sense_pin_oe_o,
    output logic                 charge_fet_drive_o,
    output logic                 discharge_fet_drive_o,
    output pfr_pkg::pfr_flt_s    fault_o
);
    import pfr_pkg::*;
    localparam int NQ = 21;

    // synchronisers
    logic [16:0] s1_r;
    logic [16:0] s2_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= {cmp_i, load_sense_pin_i, charge_enable_input_i};
            s2_r <= s1_r;
        end
    end
    pfr_cmp_s cmp;
    logic     ld_hi;
    logic     charge_enable_input;
    logic     discharge_enable_input;
    assign cmp   = s2_r[16:2];
    assign ld_hi = s2_r[1];
    assign charge_enable_input  = s2_r[0];
    logic d1_r;
    logic d2_r;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            d1_r <= 1'b0;
            d2_r <= 1'b0;
        end else begin
            d1_r <= discharge_enable_input_i;
            d2_r <= d1_r;
        end
    end
    assign discharge_enable_input = d2_r;

    // sample tick divider
    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic        tick;
    always_comb begin
        tick    = (div_r == 16'(TICK_DIV - 1)); // [RULE_23]
        div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
        end
    end

    // qualifiers: index order matches samp/tgt below
    logic [NQ-1:0]        samp;
    logic [NQ-1:0]        hit;
    logic [CNT_W-1:0]     tgt [NQ];
    pfr_flt_s             flt_r;
    pfr_flt_s             flt_nxt;
    always_comb begin
        samp = {cmp.dsg_exc1,     cmp.dsg_exc2,     cmp.dsg_short,  cmp.chg_exc,
                cmp.chg_hot,      cmp.chg_hot_rec,  cmp.dsg_hot,    cmp.dsg_hot_rec,
                cmp.chg_cold,     cmp.chg_cold_rec, cmp.dsg_cold,   cmp.dsg_cold_rec,
                cmp.cell_low,     cmp.cell_low_rec, !charge_enable_input,          charge_enable_input,
                !discharge_enable_input,            discharge_enable_input,             ld_hi,          !ld_hi,
                cmp.dsg_current};
    end
    always_comb begin
        for (int i = 0; i < NQ; i++) begin
            tgt[i] = DLY_TEMP;
        end
        for (int i = 17; i < NQ; i++) begin
            tgt[i] = DLY_CUR;
        end
        tgt[20] = DLY_CUR;
        tgt[19] = DLY_CUR;
        tgt[18] = DLY_CUR;
        tgt[17] = DLY_CUR;
        tgt[8]  = DLY_VOLT;
        tgt[7]  = DLY_VOLT;
        tgt[6]  = DLY_CTRL;
        tgt[5]  = DLY_CTRL;
        tgt[4]  = DLY_CTRL;
        tgt[3]  = DLY_CTRL;
        tgt[2]  = DLY_LOAD;
        tgt[1]  = DLY_LOAD;
        tgt[0]  = 16'(STATE_CMP_TICKS);
    end
    for (genvar g = 0; g < NQ; g++) begin : g_q
        pfr_qual #(.W(CNT_W)) u_q (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .tick_i     (tick),
            .sample_i   (samp[g]),
            .target_i   (tgt[g]),
            .hit_o      (hit[g])
        );
    end
    wire q_exc1 = hit[20];
    wire q_exc2 = hit[19];
    wire q_shrt = hit[18];
    wire q_cexc = hit[17];
    wire q_ch   = hit[16];
    wire q_chr  = hit[15];
    wire q_dh   = hit[14];
    wire q_dhr  = hit[13];
    wire q_cc   = hit[12];
    wire q_ccr  = hit[11];
    wire q_dc   = hit[10];
    wire q_dcr  = hit[9];
    wire q_uv   = hit[8];
    wire q_uvr  = hit[7];
    wire q_coff = hit[6];
    wire q_con  = hit[5];
    wire q_doff = hit[4];
    wire q_don  = hit[3];
    wire q_ldp  = hit[2];
    wire q_ldr  = hit[1];
    wire q_dcur = hit[0];

    // load state and retry timer
    logic             ld_pres_r;
    logic             ld_pres_nxt;
    logic             ld_rem_r;
    logic             ld_rem_nxt;
    logic [CNT_W-1:0] ret_r;
    logic [CNT_W-1:0] ret_nxt;
    logic             ret_run_r;
    logic             ret_run_nxt;
    logic             ret_exp;
    logic             chg_byp_r;
    logic             chg_byp_nxt;
    logic             cur_on;

    function automatic logic rec_ok(input logic [1:0] mode, input logic exp,
                                    input logic load_ok);
        case (mode)
            PFR_REC_LOAD:  rec_ok = load_ok;
            PFR_REC_TIMER: rec_ok = exp;
            PFR_REC_BOTH:  rec_ok = exp && load_ok;
            default:       rec_ok = exp;
        endcase
    endfunction

    // pulldown wanted only where the load state takes part in recovery
    function automatic logic load_mode(input logic [1:0] mode);
        load_mode = (mode == PFR_REC_LOAD) || (mode == PFR_REC_BOTH);
    endfunction

    always_comb begin
        flt_nxt     = flt_r;
        ld_pres_nxt = ld_pres_r;
        ld_rem_nxt  = ld_rem_r;
        ret_nxt     = ret_r;
        ret_run_nxt = ret_run_r;
        chg_byp_nxt = chg_byp_r;
        cur_on      = flt_r.dsg_cur || flt_r.chg_cur;
        ret_exp     = ret_run_r && tick && (ret_r + 1'b1 >= RETRY_TICKS);
        if (q_ldp) begin
            ld_pres_nxt = 1'b1; // [RULE_07]
            ld_rem_nxt  = 1'b0;
        end
        if (q_ldr) begin
            ld_rem_nxt  = 1'b1; // [RULE_08]
            ld_pres_nxt = 1'b0;
        end
        if (q_exc1 || q_exc2 || q_shrt || q_cexc) begin
            ret_run_nxt = 1'b1; // [RULE_02]
            ret_nxt     = CNT_RST;
        end else if (ret_run_r && tick) begin
            ret_nxt = ret_exp ? CNT_RST : ret_r + 1'b1;
        end
        // recovery: load used only at expiry in combined mode [RULE_04]
        if (flt_r.chg_cur && rec_ok(chg_rec_mode_i, ret_exp, ld_pres_r)) begin
            flt_nxt.chg_cur = 1'b0; // [RULE_01] [RULE_03]
        end
        if (flt_r.dsg_cur && (dsg_rec_mode_i == PFR_REC_LOAD ? ld_rem_r
                : rec_ok(dsg_rec_mode_i, ret_exp, ld_rem_r))) begin
            flt_nxt.dsg_cur = 1'b0; // [RULE_21] [RULE_03]
        end
        if (ret_exp) begin
            ret_run_nxt = 1'b0;
        end
        if (q_chr) flt_nxt.chg_hot = 1'b0; // [RULE_11]
        if (q_dhr && (!dsg_hot_need_load_i || ld_rem_r)) flt_nxt.dsg_hot = 1'b0; // [RULE_13]
        if (q_ccr) flt_nxt.chg_cold = 1'b0; // [RULE_14]
        if (q_dcr) flt_nxt.dsg_cold = 1'b0; // [RULE_15]
        if (q_uvr && (!low_volt_need_load_i || ld_rem_r)) flt_nxt.cell_low = 1'b0; // [RULE_19]
        if (q_con) flt_nxt.chg_ctrl_off = 1'b0; // [RULE_17]
        if (q_don) flt_nxt.dsg_ctrl_off = 1'b0; // [RULE_18]
        // sets win over clears
        if (q_exc1 || q_exc2 || q_shrt) flt_nxt.dsg_cur = 1'b1; // [RULE_20]
        if (q_cexc) flt_nxt.chg_cur = 1'b1; // [RULE_01]
        if (q_ch) flt_nxt.chg_hot = 1'b1; // [RULE_09]
        if (q_dh) flt_nxt.dsg_hot = 1'b1; // [RULE_12]
        if (q_cc) flt_nxt.chg_cold = 1'b1; // [RULE_14]
        if (q_dc) flt_nxt.dsg_cold = 1'b1; // [RULE_15]
        if (q_uv) flt_nxt.cell_low = 1'b1; // [RULE_19]
        if (q_coff) flt_nxt.chg_ctrl_off = 1'b1; // [RULE_17]
        if (q_doff) flt_nxt.dsg_ctrl_off = 1'b1; // [RULE_18]
        // state comparator bypass of charge temperature faults
        if (!(flt_nxt.chg_hot || flt_nxt.chg_cold)) begin
            chg_byp_nxt = 1'b0;
        end else if (q_dcur) begin
            chg_byp_nxt = 1'b1; // [RULE_10]
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flt_r     <= '0;
            ld_pres_r <= 1'b0;
            ld_rem_r  <= 1'b0;
            ret_r     <= CNT_RST; // [RULE_24]
            ret_run_r <= 1'b0;
            chg_byp_r <= 1'b0;
        end else begin
            flt_r     <= flt_nxt;
            ld_pres_r <= ld_pres_nxt;
            ld_rem_r  <= ld_rem_nxt;
            ret_r     <= ret_nxt;
            ret_run_r <= ret_run_nxt;
            chg_byp_r <= chg_byp_nxt;
        end
    end

    // outputs
    logic chg_on_nxt;
    logic dsg_on_nxt;
    logic pd_nxt;
    always_comb begin
        chg_on_nxt = !(flt_r.chg_cur || flt_r.dsg_cur || flt_r.dsg_hot || flt_r.dsg_cold
                    || flt_r.chg_ctrl_off
                    || ((flt_r.chg_hot || flt_r.chg_cold) && !chg_byp_r)); // [RULE_16]
        dsg_on_nxt = !(flt_r.chg_cur || flt_r.dsg_cur || flt_r.dsg_hot || flt_r.dsg_cold
                    || flt_r.cell_low || flt_r.dsg_ctrl_off); // [RULE_16]
        pd_nxt     = ((flt_r.cell_low && low_volt_need_load_i)
                    || (flt_r.dsg_cur && load_mode(dsg_rec_mode_i))
                    || (flt_r.chg_cur && load_mode(chg_rec_mode_i))); // [RULE_05] [RULE_06]
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            charge_fet_drive_o    <= 1'b0;
            discharge_fet_drive_o <= 1'b0;
            load_sense_pin_oe_o   <= 1'b0; // [RULE_24]
        end else begin
            charge_fet_drive_o    <= chg_on_nxt;
            discharge_fet_drive_o <= dsg_on_nxt;
            load_sense_pin_oe_o   <= pd_nxt;
        end
    end
    assign load_sense_pin_o = 1'b0;
    assign fault_o          = flt_r;

    a_pin_idle : assert property (@(posedge core_clk_i) disable iff (rst_i)
        !(flt_r.cell_low || cur_on) |=> !load_sense_pin_oe_o) // [RULE_05]
        else $error("load pin driven without fault");
    a_pd_on_fault : assert property (@(posedge core_clk_i) disable iff (rst_i)
        (flt_r.dsg_cur && dsg_rec_mode_i == PFR_REC_LOAD) |=> load_sense_pin_oe_o) // [RULE_06]
        else $error("pulldown missing during current fault");
    a_retry_start : assert property (@(posedge core_clk_i) disable iff (rst_i)
        (q_exc1 || q_shrt) |=> ret_run_r && ret_r == CNT_RST) // [RULE_02]
        else $error("retry timer not started");
    a_both_off : assert property (@(posedge core_clk_i) disable iff (rst_i)
        q_shrt |=> ##1 !charge_fet_drive_o && !discharge_fet_drive_o) // [RULE_20]
        else $error("short circuit did not turn off drivers");
    a_timer_rec : assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ret_exp && flt_r.dsg_cur && dsg_rec_mode_i == PFR_REC_TIMER && !q_exc1
         && !q_exc2 && !q_shrt) |=> !flt_r.dsg_cur) // [RULE_03]
        else $error("timer expiry did not recover");
    a_both_wait : assert property (@(posedge core_clk_i) disable iff (rst_i)
        (flt_r.dsg_cur && dsg_rec_mode_i == PFR_REC_BOTH && !ret_exp) |=> flt_r.dsg_cur) // [RULE_04]
        else $error("combined recovery before expiry");
    a_chg_hot_off : assert property (@(posedge core_clk_i) disable iff (rst_i)
        (flt_r.chg_hot && !chg_byp_r) |=> !charge_fet_drive_o) // [RULE_09]
        else $error("charge on during charge hot fault");
    a_dsg_hot_off : assert property (@(posedge core_clk_i) disable iff (rst_i)
        flt_r.dsg_hot |=> !charge_fet_drive_o && !discharge_fet_drive_o) // [RULE_12]
        else $error("drivers on during discharge hot fault");
    a_low_volt : assert property (@(posedge core_clk_i) disable iff (rst_i)
        flt_r.cell_low |=> !discharge_fet_drive_o) // [RULE_19]
        else $error("discharge on during low voltage");
    a_ctrl_off : assert property (@(posedge core_clk_i) disable iff (rst_i)
        q_coff |=> ##1 !charge_fet_drive_o) // [RULE_17]
        else $error("charge control input ignored");
    a_dctrl_off : assert property (@(posedge core_clk_i) disable iff (rst_i)
        q_doff |=> ##1 !discharge_fet_drive_o) // [RULE_18]
        else $error("discharge control input ignored");
endmodule
`default_nettype wire

// ### verilog/pfr_pkg.sv
/*
 * package of constants and types for the
 * pack fault recovery controller.
 * assumes a single 20 MHz core clock and an internal sample tick divider.
 */
// Overview of operation
// [RULE_01] charge overcurrent recovers by load, timer, or both
// [RULE_02] recovery timer starts when current fault qualifies
// [RULE_03] timer expiry re-enables both fet drivers
// [RULE_04] combined mode checks load only at expiry
// [RULE_05] load pin undriven while no uv/current fault
// [RULE_06] weak pulldown on load pin during faults; code: only uv needing load and current faults in load or combined mode
// [RULE_07] load present: pin high for deglitch
// [RULE_08] load removed: pin low for deglitch
// [RULE_09] charge hot fault disables charge driver
// [RULE_10] discharge current re-enables charge under temp fault
// [RULE_11] charge hot fault clears after recovery delay
// [RULE_12] discharge hot fault disables both drivers
// [RULE_13] discharge hot clears, optionally needing load removal
// [RULE_14] charge cold fault disables charge, then recovers
// [RULE_15] discharge cold fault disables both, then recovers
// [RULE_16] driver on only when all its faults clear
// [RULE_17] charge enable input deglitched controls charge driver
// [RULE_18] discharge enable input deglitched controls discharge driver
// [RULE_19] undervoltage recovers after load removal and voltage
// [RULE_20] discharge excess current or short disables both
// [RULE_21] discharge current faults recover by timer/load option
// [RULE_22] up/down sample counter qualifies each fault
// [RULE_23] all delays derive from one sample tick
// [RULE_24] reset clears timers, counters, pulldown
`default_nettype none
package pfr_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TICK_US         = 100;
    localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned CNT_W           = 16;
    localparam int unsigned STATE_CMP_US    = 700;
    localparam int unsigned STATE_CMP_TICKS = STATE_CMP_US / TICK_US;
    localparam logic [CNT_W-1:0] DLY_CUR    = 16'h000a;
    localparam logic [CNT_W-1:0] DLY_TEMP   = 16'h0014;
    localparam logic [CNT_W-1:0] DLY_VOLT   = 16'h0014;
    localparam logic [CNT_W-1:0] DLY_CTRL   = 16'h0005;
    localparam logic [CNT_W-1:0] DLY_LOAD   = 16'h0005;
    localparam logic [CNT_W-1:0] DLY_RETRY  = 16'h2710;
    localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;

    typedef enum logic [1:0] {
        PFR_REC_LOAD  = 2'h0,
        PFR_REC_TIMER = 2'h1,
        PFR_REC_BOTH  = 2'h2
    } pfr_rec_e;

    typedef struct packed {
        logic dsg_exc1;
        logic dsg_exc2;
        logic dsg_short;
        logic chg_exc;
        logic chg_hot;
        logic dsg_hot;
        logic chg_cold;
        logic dsg_cold;
        logic cell_low;
        logic cell_low_rec;
        logic chg_hot_rec;
        logic dsg_hot_rec;
        logic chg_cold_rec;
        logic dsg_cold_rec;
        logic dsg_current;
    } pfr_cmp_s;

    typedef struct packed {
        logic dsg_cur;
        logic chg_cur;
        logic chg_hot;
        logic dsg_hot;
        logic chg_cold;
        logic dsg_cold;
        logic cell_low;
        logic chg_ctrl_off;
        logic dsg_ctrl_off;
    } pfr_flt_s;
endpackage
`default_nettype wire

// ### verilog/pfr_qual.sv
/*
 * up/down sample counter qualifier: fires one pulse when the count of
 * samples past the threshold reaches the target.
 * assumes sample_i is synchronous and tick_i is a one-cycle enable.
 */
`timescale 1ns/1ps
`default_nettype none
module pfr_qual #(
    parameter int unsigned W = 16
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic         sample_i,
    input  wire logic [W-1:0] target_i,
    output logic              hit_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         hit_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        hit_nxt = 1'b0;
        if (tick_i) begin
            if (sample_i) begin
                if (cnt_r + 1'b1 >= target_i) begin
                    cnt_nxt = '0; // [RULE_22]
                    hit_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 1'b1; // [RULE_22]
                end
            end else if (cnt_r != '0) begin
                cnt_nxt = cnt_r - 1'b1; // [RULE_22]
            end
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0; // [RULE_24]
            hit_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hit_o <= hit_nxt;
        end
    end
    a_qual_no_early : assert property (@(posedge core_clk_i) disable iff (rst_i)
        hit_o |-> $past(tick_i) && $past(sample_i)) // [RULE_22]
        else $error("qualifier fired without a past sample");
endmodule
`default_nettype wire

// ### dv/pfr_pin_model.sv
/*
 * far side model of the load sense pin: external load and weak pulldown.
 * assumes the bench changes ext_load_i at the clock's falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pfr_pin_model (
    input  wire logic core_clk_i,
    input  wire logic ext_load_i,
    input  wire logic pin_dat_i,
    input  wire logic pin_oe_i,
    output logic      pin_lvl_o
);
    logic float_r = 1'b0;

    // a released pin keeps its charge for one cycle, then bleeds low
    always_ff @(posedge core_clk_i) begin
        float_r <= ext_load_i || (pin_oe_i && pin_dat_i);
    end

    // a present load overpowers the weak pulldown
    always_comb begin
        if (ext_load_i) begin
            pin_lvl_o = 1'b1;
        end else if (pin_oe_i) begin
            pin_lvl_o = pin_dat_i;
        end else begin
            pin_lvl_o = float_r;
        end
    end
endmodule
`default_nettype wire

// ### dv/pfr_tb.sv
/*
 * self-checking bench of the fault recovery controller.
 * assumes a shortened sample tick and retry count, and the pin model.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, a); end end
module testbench;
    import pfr_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    pfr_cmp_s   cmp      = '0;
    logic       ext_load = 1'b1;
    logic       chg_en   = 1'b1;
    logic       dsg_en   = 1'b1;
    logic [1:0] chg_mode = 2'h1;
    logic [1:0] dsg_mode = 2'h1;
    logic       hot_load = 1'b0;
    logic       low_load = 1'b1;
    logic       pin_lvl;
    logic       pin_dat;
    logic       pin_oe;
    logic       chg_o;
    logic       dsg_o;
    pfr_flt_s   flt;
    int         fail_count  = 0;
    int         check_count = 0;
    int         cyc         = 0;
    int         i;

    always #25 core_clk = ~core_clk;

    // short tick and retry count keep the run brief
    pfr_ctrl #(.TICK_DIV(4), .RETRY_TICKS(16'h0004)) uut (
        .core_clk_i               (core_clk),
        .rst_i                    (rst),
        .cmp_i                    (cmp),
        .load_sense_pin_i         (pin_lvl),
        .charge_enable_input_i    (chg_en),
        .discharge_enable_input_i (dsg_en),
        .chg_rec_mode_i           (chg_mode),
        .dsg_rec_mode_i           (dsg_mode),
        .dsg_hot_need_load_i      (hot_load),
        .low_volt_need_load_i     (low_load),
        .load_sense_pin_o         (pin_dat),
        .load_sense_pin_oe_o      (pin_oe),
        .charge_fet_drive_o       (chg_o),
        .discharge_fet_drive_o    (dsg_o),
        .fault_o                  (flt)
    );

    pfr_pin_model far (
        .core_clk_i (core_clk),
        .ext_load_i (ext_load),
        .pin_dat_i  (pin_dat),
        .pin_oe_i   (pin_oe),
        .pin_lvl_o  (pin_lvl)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // waits a bounded time for the drives to settle, then compares
    task automatic expect_drv(input logic [1:0] e, input string nm);
        int n;
        n = 0;
        while ({chg_o, dsg_o} !== e && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(nm, e, {chg_o, dsg_o})
    endtask

    task automatic hold_drv(input logic [1:0] e, input string nm);
        repeat (200) @(negedge core_clk);
        `CHK(nm, e, {chg_o, dsg_o})
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(negedge core_clk);
        `CHK("reset outputs", 3'h0, {chg_o, dsg_o, pin_oe})
        `CHK("reset faults", 9'h000, flt)
        rst = 1'b0;
    endtask

    task automatic end_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, fail_count);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        do_reset();
        expect_drv(2'b11, "release");
        `CHK("idle pin", 1'b0, pin_oe)
        end_test("reset");

        // hot and cold faults, one at a time
        for (i = 0; i < 4; i++) begin
            cmp = pfr_cmp_s'(15'h0400 >> i);
            expect_drv({1'b0, ~i[0]}, "temp fault");
            cmp = pfr_cmp_s'(15'h0010 >> i);
            expect_drv(2'b11, "temp clear");
        end
        end_test("temperature");

        cmp = pfr_cmp_s'(15'h0500);
        expect_drv(2'b01, "two faults");
        cmp = pfr_cmp_s'(15'h0110);
        hold_drv(2'b01, "one left");
        cmp = pfr_cmp_s'(15'h0101);
        expect_drv(2'b11, "state cmp");
        cmp = pfr_cmp_s'(15'h0004);
        hold_drv(2'b11, "cold clear");
        `CHK("cold flag", 1'b0, flt.chg_cold)
        end_test("multiple");

        for (i = 0; i < 2; i++) begin
            chg_en = i[0];
            dsg_en = ~i[0];
            expect_drv({i[0], ~i[0]}, "ctrl off");
            chg_en = 1'b1;
            dsg_en = 1'b1;
            expect_drv(2'b11, "ctrl on");
        end
        end_test("control");

        // current faults under timer recovery, mode 3 acting as timer
        for (i = 0; i < 4; i++) begin
            chg_mode = i[0] ? 2'h3 : 2'h1;
            dsg_mode = i[0] ? 2'h3 : 2'h1;
            cmp = pfr_cmp_s'(15'h4000 >> i);
            expect_drv(2'b00, "cur fault");
            `CHK("cur flag", 1'b1, (i == 3) ? flt.chg_cur : flt.dsg_cur)
            `CHK("no pulldown", 1'b0, pin_oe)
            cmp = '0;
            repeat (8) @(negedge core_clk);
            `CHK("retry wait", 2'b00, {chg_o, dsg_o})
            expect_drv(2'b11, "retry");
        end
        end_test("timer");

        dsg_mode = 2'h0;
        cmp = pfr_cmp_s'(15'h1000);
        expect_drv(2'b00, "short fault");
        `CHK("pulldown on", 1'b1, pin_oe)
        `CHK("pin data", 1'b0, pin_dat)
        cmp = '0;
        hold_drv(2'b00, "load kept");
        ext_load = 1'b0;
        expect_drv(2'b11, "load removed");
        repeat (4) @(negedge core_clk);
        `CHK("pulldown off", 1'b0, pin_oe)
        end_test("discharge load");

        chg_mode = 2'h0;
        cmp = pfr_cmp_s'(15'h0800);
        expect_drv(2'b00, "chg cur fault");
        `CHK("pulldown chg", 1'b1, pin_oe)
        cmp = '0;
        hold_drv(2'b00, "no load");
        ext_load = 1'b1;
        expect_drv(2'b11, "load present");
        end_test("charge load");

        cmp = pfr_cmp_s'(15'h0040);
        expect_drv(2'b10, "low volt");
        `CHK("pulldown low", 1'b1, pin_oe)
        cmp = pfr_cmp_s'(15'h0020);
        hold_drv(2'b10, "load still on");
        ext_load = 1'b0;
        expect_drv(2'b11, "low volt clear");
        end_test("low voltage");

        // discharge hot recovery that also waits for load removal
        hot_load = 1'b1;
        ext_load = 1'b1;
        cmp = pfr_cmp_s'(15'h0200);
        expect_drv(2'b00, "hot with load");
        cmp = pfr_cmp_s'(15'h0008);
        hold_drv(2'b00, "hot needs removal");
        ext_load = 1'b0;
        expect_drv(2'b11, "hot load removed");
        end_test("hot recovery");

        // combined mode with a load still present at expiry
        ext_load = 1'b1;
        dsg_mode = 2'h2;
        repeat (40) @(negedge core_clk);
        cmp = pfr_cmp_s'(15'h2000);
        expect_drv(2'b00, "both fault");
        cmp = '0;
        hold_drv(2'b00, "expiry with load");
        do_reset();
        expect_drv(2'b11, "second release");
        `CHK("oe after reset", 1'b0, pin_oe)
        end_test("combined");
        conclude();
    end
endmodule
`default_nettype wire
